/* src/regbank_map.svh */
// Register map constants of the dual-channel register bank and its serial link.
// Assumes nothing beyond being included by the package and both ends.
`ifndef REGBANK_MAP_SVH
`define REGBANK_MAP_SVH

// Address width carried in the instruction word
`define ADDR_W 13
// Fixed register offsets
`define ADDR_PORT_CFG 13'h000
`define ADDR_CHIP_ID 13'h001
`define ADDR_CHIP_GRADE 13'h002
`define ADDR_CHAN_IDX 13'h005
`define ADDR_COMMIT 13'h0FF
// Shadowed ranges: function registers, then digital feature control
`define ADDR_FUNC_LO 13'h008
`define ADDR_FUNC_HI 13'h020
`define ADDR_DIG_LO 13'h03A
`define ADDR_DIG_HI 13'h03E
// Number of shadowed locations (25 function plus 5 digital)
`define NREG 30
// Index of the first digital feature location in the shadow arrays
`define DIG_BASE 25
// Reset values
`define RST_PORT_CFG 8'h18
`define RST_CHAN_IDX 2'h3
`define RST_POWER_MODES 8'h00
`define RST_GLOBAL_CLK 8'h01
`define RST_OUTPUT_MODE 8'h05
// Shadow indices of locations with non-zero defaults
`define IDX_GLOBAL_CLK 1
`define IDX_OUTPUT_MODE 12
// Port configuration field positions (mirrored nibbles)
`define PCFG_LSB_HI 6
`define PCFG_LSB_LO 1
`define PCFG_SOFT_HI 5
`define PCFG_SOFT_LO 2
// Commit register field
`define COMMIT_BIT 0
// Instruction word fields
`define INSTR_RW 15
`define INSTR_W1 14
`define INSTR_W0 13
// Timing: least SCLK half period and system clock period, in ns
`define SCLK_HALF_NS 400
`define CLK_PERIOD_NS 50
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Frame length of a single-byte access in bits
`define FRAME_BITS 24

`endif

/* src/regbank_pkg.sv */
// Shared types of the register bank device end and host end.
// Assumes regbank_map.svh is on the include path.
package regbank_pkg;
  `include "regbank_map.svh"

  // Frame phase of the device serial engine
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA = 2'b10
  } phase_e;

  // Host sequencer states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SHIFT = 2'b01,
    HS_DONE = 2'b10
  } host_state_e;

  // One byte register value
  typedef logic [7:0] byte_t;
  // Register address as carried on the link
  typedef logic [`ADDR_W-1:0] addr_t;
  // Shadow or active copies for both channels
  typedef byte_t [1:0][`NREG-1:0] bank_t;

  // Whole device state
  typedef struct packed {
    logic sclkMeta;
    logic sclkSync;
    logic sclkPrev;
    logic csbMeta;
    logic csbSync;
    logic sdiMeta;
    logic sdiSync;
    phase_e phase;
    logic [3:0] bitCnt;
    logic [15:0] shifter;
    logic isRead;
    addr_t addr;
    byte_t txByte;
    logic sdoBit;
    logic drive;
    logic lsbFirst;
    logic [1:0] chanSel;
    bank_t shadow;
    bank_t active;
  } dev_state_s;

  // Whole host state
  typedef struct packed {
    host_state_e state;
    logic sdioMeta;
    logic sdioSync;
    logic sclk;
    logic csbN;
    logic sdo;
    logic sdoOeN;
    logic [15:0] div;
    logic [4:0] bitIdx;
    logic [`FRAME_BITS-1:0] frame;
    logic isRead;
    logic lsb;
    byte_t rx;
    logic rspValid;
    byte_t rspData;
  } host_state_s;
endpackage

/* src/spi_link_if.sv */
// Three-wire serial link between the host end and the register bank.
// The shared data wire idles high, as with a pull-up, when nobody drives.
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;       // Shift clock, made by the host
  logic csbN;       // Frame select, active low
  logic hostSdo;    // Host data toward the wire
  logic hostSdoOeN; // Host drives the wire while low
  logic devSdo;     // Device data toward the wire
  logic devSdoOeN;  // Device drives the wire while low
  logic sdio;       // Resolved wire level

  // Device has priority only because the host releases before readback
  assign sdio = !devSdoOeN ? devSdo : (!hostSdoOeN ? hostSdo : 1'b1);

  modport host (output sclk, output csbN, output hostSdo, output hostSdoOeN, input sdio);
  modport device (input sclk, input csbN, input sdio, output devSdo, output devSdoOeN);
endinterface

/* src/regbank_device.sv */
// Device end: serial slave plus shadowed per-channel configuration registers.
// Assumes SCLK half periods of at least SCLK_HALF_CYC system clocks, since all
// link pins are sampled through two flip-flops on clk_sys.
`timescale 1ns/1ps
`include "regbank_map.svh"

// Notes on behaviour
// (R1) Decode config, index, commit, function, digital ranges
// (R2) Host writes zero into unused bits
// (R3) Host never writes fully open locations
// (R4) Reset loads documented defaults into registers
// (R5) Shadowed range writes wait for commit
// (R6) Writing 0x01 to 0xFF commits all shadows
// (R7) Commit bit clears itself after the update
// (R8) Local registers per channel, chosen by index
// (R9) Both selects set: write updates both channels
// (R10) Both selects set: read returns channel A
// (R11) Host selects one channel before reading; the bench also reads local locations with both selected
// (R12) Global registers ignore channel selection
// (R13) Port config mirrored nibbles, default 0x18
module regbank_device #(
  parameter logic [`NREG-1:0] LOCAL_MASK = 30'h3FFFFFFD, // Bit set marks a local location
  parameter logic [7:0] CHIP_ID = 8'h5A,                 // Arbitrary identification value
  parameter logic [1:0] CHIP_GRADE = 2'h0                // Arbitrary grade code
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial link
  spi_link_if.device link,
  // Live register images, channel A and channel B, index 0 at the low byte
  output logic [`NREG*8-1:0] activeRegsA,
  output logic [`NREG*8-1:0] activeRegsB,
  // Current shift order of data bytes
  output logic lsbFirst
);
  import regbank_pkg::*;

  // Shadow index of an address, or -1 where it is outside both shadowed ranges
  function automatic int funcIndex(input addr_t a);
    int idx;
    idx = -1;
    if (a >= `ADDR_FUNC_LO && a <= `ADDR_FUNC_HI) begin
      idx = int'(a - `ADDR_FUNC_LO);
    end else if (a >= `ADDR_DIG_LO && a <= `ADDR_DIG_HI) begin
      idx = int'(a - `ADDR_DIG_LO) + `DIG_BASE;
    end
    return idx;
  endfunction

  // Bit reversal for the LSB-first order
  function automatic byte_t reverse(input byte_t b);
    byte_t r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Loads every register with its default; frame tracking is left alone
  function automatic dev_state_s loadDefaults(input dev_state_s s);
    dev_state_s r;
    r = s;
    r.lsbFirst = 1'b0; // R13
    r.chanSel = `RST_CHAN_IDX; // R4
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < `NREG; i++) begin
        r.shadow[c][i] = 8'h00; // R4
      end
      r.shadow[c][0] = `RST_POWER_MODES;
      r.shadow[c][`IDX_GLOBAL_CLK] = `RST_GLOBAL_CLK;
      r.shadow[c][`IDX_OUTPUT_MODE] = `RST_OUTPUT_MODE;
    end
    r.active = r.shadow; // R4
    return r;
  endfunction

  // Constant state taken under reset
  function automatic dev_state_s resetState();
    dev_state_s r;
    r = '0;
    r.csbMeta = 1'b1; // Link counts as idle until sampled
    r.csbSync = 1'b1;
    r.phase = PH_IDLE;
    r = loadDefaults(r);
    return r;
  endfunction

  localparam dev_state_s RST_STATE = resetState();

  // Byte seen by a read of one address
  function automatic byte_t readByte(input dev_state_s s, input addr_t a);
    byte_t d;
    int idx;
    int ch;
    d = 8'h00;
    idx = funcIndex(a);
    ch = 0;
    case (a)
      `ADDR_PORT_CFG: begin
        // Mirrored nibbles, fixed ones in bits 4 and 3, soft reset reads back clear
        d = 8'h18; // R13
        d[`PCFG_LSB_HI] = s.lsbFirst; // R13
        d[`PCFG_LSB_LO] = s.lsbFirst;
      end
      `ADDR_CHIP_ID: d = CHIP_ID;
      `ADDR_CHIP_GRADE: d = {2'b00, CHIP_GRADE, 4'h0};
      `ADDR_CHAN_IDX: d = {6'h00, s.chanSel};
      `ADDR_COMMIT: d = 8'h00; // R7
      default: begin
        if (idx >= 0) begin
          // Channel B only when it alone is selected; both set gives A
          if (LOCAL_MASK[idx] && s.chanSel == 2'b10) begin // R10
            ch = 1;
          end
          d = s.shadow[ch][idx]; // R8
        end
      end
    endcase
    return d;
  endfunction

  // Effect of one written byte; unsupported and read-only locations ignore it
  function automatic dev_state_s applyWrite(input dev_state_s s, input addr_t a, input byte_t d);
    dev_state_s r;
    int idx;
    r = s;
    idx = funcIndex(a);
    case (a)
      `ADDR_PORT_CFG: begin
        r.lsbFirst = d[`PCFG_LSB_HI] | d[`PCFG_LSB_LO]; // R13
        // Soft reset acts at once and never stays set
        if (d[`PCFG_SOFT_HI] | d[`PCFG_SOFT_LO]) begin
          r = loadDefaults(r); // R13
        end
      end
      `ADDR_CHAN_IDX: r.chanSel = d[1:0]; // R8
      `ADDR_COMMIT: begin
        // All shadows go live in one cycle; the bit is never stored
        if (d[`COMMIT_BIT]) begin
          r.active = r.shadow; // R6 R7
        end
      end
      default: begin
        if (idx >= 0) begin
          for (int c = 0; c < 2; c++) begin
            // Global locations write the shared value into both copies
            if (r.chanSel[c] || !LOCAL_MASK[idx]) begin // R9 R12
              r.shadow[c][idx] = d; // R5
            end
          end
        end
      end
    endcase
    return r; // R1
  endfunction

  dev_state_s st_reg; // Registered state
  dev_state_s st_next; // Next state
  logic sclkRise; // Synchronised SCLK rising edge
  logic sclkFall; // Synchronised SCLK falling edge
  logic [15:0] shiftIn; // Shifter with the current bit appended
  byte_t dataIn; // Received data byte in register order

  // Edge detection looks only at the second and third flip-flops
  assign sclkRise = st_reg.sclkSync & ~st_reg.sclkPrev;
  assign sclkFall = ~st_reg.sclkSync & st_reg.sclkPrev;
  assign shiftIn = {st_reg.shifter[14:0], st_reg.sdiSync};
  assign dataIn = st_reg.lsbFirst ? reverse(shiftIn[7:0]) : shiftIn[7:0];

  // Serial engine and register file
  always_comb begin
    st_next = st_reg;
    st_next.sclkMeta = link.sclk;
    st_next.sclkSync = st_reg.sclkMeta;
    st_next.sclkPrev = st_reg.sclkSync;
    st_next.csbMeta = link.csbN;
    st_next.csbSync = st_reg.csbMeta;
    st_next.sdiMeta = link.sdio;
    st_next.sdiSync = st_reg.sdiMeta;
    if (st_reg.csbSync) begin
      // Frame select high ends any frame and releases the wire
      st_next.phase = PH_IDLE;
      st_next.drive = 1'b0;
      st_next.bitCnt = 4'h0;
    end else begin
      case (st_reg.phase)
        PH_IDLE: begin
          st_next.phase = PH_INSTR;
          st_next.bitCnt = 4'h0;
        end
        PH_INSTR: begin
          if (sclkRise) begin
            st_next.shifter = shiftIn;
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
            if (st_reg.bitCnt == 4'hF) begin
              // Length bits are not used: the frame streams until deselect
              st_next.isRead = shiftIn[`INSTR_RW];
              st_next.addr = shiftIn[`ADDR_W-1:0];
              st_next.phase = PH_DATA;
              st_next.bitCnt = 4'h0;
              st_next.txByte = st_reg.lsbFirst ? reverse(readByte(st_reg, shiftIn[`ADDR_W-1:0]))
                                               : readByte(st_reg, shiftIn[`ADDR_W-1:0]);
            end
          end
        end
        PH_DATA: begin
          // Readback bits change on the falling edge so the host samples on the rise
          if (st_reg.isRead && sclkFall) begin
            st_next.sdoBit = st_reg.txByte[7];
            st_next.txByte = {st_reg.txByte[6:0], 1'b0};
            st_next.drive = 1'b1;
          end
          if (sclkRise) begin
            st_next.shifter = shiftIn;
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
            if (st_reg.bitCnt == 4'h7) begin
              st_next.bitCnt = 4'h0;
              st_next.addr = st_reg.addr - `ADDR_W'(1);
              if (st_reg.isRead) begin
                st_next.txByte = st_reg.lsbFirst ? reverse(readByte(st_reg, st_next.addr))
                                                 : readByte(st_reg, st_next.addr);
              end else begin
                st_next = applyWrite(st_next, st_reg.addr, dataIn);
              end
            end
          end
        end
        default: st_next.phase = PH_IDLE;
      endcase
    end
  end

  // State register; reset takes a constant image
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= RST_STATE; // R4
    end else begin
      st_reg <= st_next;
    end
  end

  // Live images go out through one loop over locations
  for (genvar i = 0; i < `NREG; i++) begin : g_out
    assign activeRegsA[i*8 +: 8] = st_reg.active[0][i];
    assign activeRegsB[i*8 +: 8] = st_reg.active[1][i];
  end

  // Link outputs, enable low while driving
  assign link.devSdo = st_reg.sdoBit;
  assign link.devSdoOeN = ~st_reg.drive;
  assign lsbFirst = st_reg.lsbFirst;
endmodule

/* src/regbank_host.sv */
// Host end: turns single-byte read and write requests into serial frames.
// Assumes the device samples the link on clk_sys through two flip-flops.
`timescale 1ns/1ps
`include "regbank_map.svh"
module regbank_host #(
  parameter int HALF_CYC = `SCLK_HALF_CYC // System clocks per SCLK half period
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request port
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire regbank_pkg::addr_t reqAddr,
  input wire regbank_pkg::byte_t reqData,
  input wire logic lsbFirst,
  // Answer port
  output logic rspValid,
  output regbank_pkg::byte_t rspData,
  // Serial link
  spi_link_if.host link
);
  import regbank_pkg::*;

  // Readback needs time for both synchronisers and the device turnaround
  if (HALF_CYC < 8 || HALF_CYC > 65535) begin : g_chk
    $error("HALF_CYC out of range");
  end

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

  // Bit reversal for the LSB-first order
  function automatic byte_t reverse(input byte_t b);
    byte_t r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  host_state_s st_reg; // Registered state
  host_state_s st_next; // Next state
  byte_t txData; // Data byte in wire order

  assign txData = lsbFirst ? reverse(reqData) : reqData;

  // Frame sequencer
  always_comb begin
    st_next = st_reg;
    st_next.sdioMeta = link.sdio;
    st_next.sdioSync = st_reg.sdioMeta;
    st_next.rspValid = 1'b0;
    case (st_reg.state)
      HS_IDLE: begin
        if (reqValid) begin
          // Length bits zero: one data byte; unused data bits are the caller's to zero
          st_next.frame = {reqRead, 2'b00, reqAddr, reqRead ? 8'h00 : txData}; // R2 R3
          st_next.sdo = reqRead;
          st_next.sdoOeN = 1'b0;
          st_next.csbN = 1'b0;
          st_next.sclk = 1'b0;
          st_next.div = 16'h0000;
          st_next.bitIdx = 5'h00;
          st_next.isRead = reqRead;
          st_next.lsb = lsbFirst;
          st_next.state = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        st_next.div = st_reg.div + 16'h0001;
        if (st_reg.div == HALF_M1) begin
          st_next.div = 16'h0000;
          st_next.sclk = ~st_reg.sclk;
          if (!st_reg.sclk) begin
            // Rising edge: readback bits are sampled here
            st_next.bitIdx = st_reg.bitIdx + 5'h01;
            if (st_reg.isRead && st_reg.bitIdx >= 5'd16) begin
              st_next.rx = {st_reg.rx[6:0], st_reg.sdioSync};
            end
          end else if (st_reg.bitIdx == 5'(`FRAME_BITS)) begin
            st_next.state = HS_DONE;
          end else begin
            // Falling edge: next bit, or release the wire for readback
            st_next.sdo = st_reg.frame[5'(`FRAME_BITS - 1) - st_reg.bitIdx];
            st_next.sdoOeN = st_reg.isRead && st_reg.bitIdx >= 5'd16;
          end
        end
      end
      HS_DONE: begin
        // Deselect held for one half period: the device streams one more bit after the last fall
        // and lets go of the wire only once its synchroniser has seen the frame select high
        st_next.csbN = 1'b1;
        st_next.sdoOeN = 1'b1;
        st_next.div = st_reg.div + 16'h0001;
        if (st_reg.div == HALF_M1) begin
          st_next.div = 16'h0000;
          st_next.rspValid = st_reg.isRead;
          st_next.rspData = st_reg.lsb ? reverse(st_reg.rx) : st_reg.rx;
          st_next.state = HS_IDLE;
        end
      end
      default: st_next.state = HS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{state: HS_IDLE, sdioMeta: 1'b1, sdioSync: 1'b1, sclk: 1'b0, csbN: 1'b1,
                  sdo: 1'b0, sdoOeN: 1'b1, div: 16'h0000, bitIdx: 5'h00, frame: '0,
                  isRead: 1'b0, lsb: 1'b0, rx: 8'h00, rspValid: 1'b0, rspData: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reqReady = (st_reg.state == HS_IDLE);
  assign rspValid = st_reg.rspValid;
  assign rspData = st_reg.rspData;
  assign link.sclk = st_reg.sclk;
  assign link.csbN = st_reg.csbN;
  assign link.hostSdo = st_reg.sdo;
  assign link.hostSdoOeN = st_reg.sdoOeN;
endmodule

/* verification/regbank_link_assertions.sv */
// Concurrent checks on the three-wire link between the host end and the register bank.
// Assumes one clk_sys domain, rstn active low, and SCLK half periods of eight clocks.
`timescale 1ns/1ps
module regbank_link_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link signals as seen on the interface
  input wire logic sclk,
  input wire logic csbN,
  input wire logic hostSdo,
  input wire logic hostSdoOeN,
  input wire logic devSdo,
  input wire logic devSdoOeN,
  input wire logic sdio
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic sclkPrev_reg;        // Shift clock one cycle back, for rise detection
  logic [4:0] riseCnt_reg;   // Shift clock rises seen in the current frame
  logic [4:0] riseCnt_next;  // Next value of the rise count

  // Count rises inside a frame; cleared while the frame select is high
  always_comb begin
    riseCnt_next = riseCnt_reg;
    if (csbN) begin
      riseCnt_next = 5'h00;
    end else if (sclk && !sclkPrev_reg) begin
      riseCnt_next = riseCnt_reg + 5'h01;
    end
  end

  // Helper registers; reset keeps a stale count from leaking into the next frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_reg <= 1'b0;
      riseCnt_reg <= 5'h00;
    end else begin
      sclkPrev_reg <= sclk;
      riseCnt_reg <= riseCnt_next;
    end
  end

  // One high half period of exactly eight clocks, then low
  sequence s_highHalf;
    sclk [*8] ##1 !sclk;
  endsequence

  property p_idleClkLow;
    csbN |-> !sclk;
  endproperty
  a_idleClkLow: assert property (p_idleClkLow) else $error("shift clock high outside a frame");

  property p_halfPeriod;
    $rose(sclk) |-> s_highHalf;
  endproperty
  a_halfPeriod: assert property (p_halfPeriod) else $error("shift clock high phase length wrong");

  property p_frameLength;
    $rose(csbN) |-> riseCnt_reg == 5'h18;
  endproperty
  a_frameLength: assert property (p_frameLength) else $error("frame did not carry 24 bits");

  property p_widthBits;
    sclk && !sclkPrev_reg && (riseCnt_reg == 5'h01 || riseCnt_reg == 5'h02) |-> !sdio;
  endproperty
  a_widthBits: assert property (p_widthBits) else $error("length bits of instruction not zero");

  property p_noClash;
    !devSdoOeN |-> hostSdoOeN;
  endproperty
  a_noClash: assert property (p_noClash) else $error("both ends drive the data wire");

  property p_devTurn;
    $fell(devSdoOeN) |-> riseCnt_reg == 5'h10 && !csbN;
  endproperty
  a_devTurn: assert property (p_devTurn) else $error("device drove before the data phase");

  property p_devRelease;
    csbN [*6] |-> devSdoOeN;
  endproperty
  a_devRelease: assert property (p_devRelease) else $error("device still drives after frame end");

  property p_hostRelease;
    csbN && $past(csbN) |-> hostSdoOeN;
  endproperty
  a_hostRelease: assert property (p_hostRelease) else $error("host drives the wire between frames");

  property p_hostStable;
    sclk && $past(sclk) && !hostSdoOeN |-> $stable(hostSdo);
  endproperty
  a_hostStable: assert property (p_hostStable) else $error("host data moved while clock high");

  property p_devStable;
    sclk && $past(sclk) && !devSdoOeN |-> $stable(devSdo);
  endproperty
  a_devStable: assert property (p_devStable) else $error("device data moved while clock high");
endmodule

/* verification/testbench.sv */
// Self-checking bench: host end and register bank joined over the link interface.
// Assumes the map header is on the include path; requests go through the host port.
`timescale 1ns/1ps
`include "regbank_map.svh"
module testbench;
  import regbank_pkg::*;
  // Clock, reset and host request side
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  addr_t reqAddr = '0;
  byte_t reqData = '0;
  logic hostLsb = 1'b0;  // Data bit order used by the host
  logic reqReady;
  logic rspValid;
  logic devLsb;          // Bit order the device currently uses
  byte_t rspData;
  logic [`NREG*8-1:0] activeRegsA;
  logic [`NREG*8-1:0] activeRegsB;
  logic [`NREG*8-1:0] defVec;  // Expected live image after any reset
  int miscompares = 0;
  int checksDone = 0;
  // Edges of the shadowed ranges and their image positions
  addr_t edgeAddr [4] = '{13'h008, 13'h020, 13'h03A, 13'h03E};
  int edgeIdx [4] = '{0, 24, 25, 29};
  // Addresses just outside the decoded ranges
  addr_t openAddr [5] = '{13'h003, 13'h007, 13'h021, 13'h039, 13'h03F};

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  spi_link_if link();
  regbank_host #(.HALF_CYC(8)) regbank_host_inst (.clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData), .lsbFirst(hostLsb),
    .rspValid(rspValid), .rspData(rspData), .link(link.host));
  regbank_device regbank_device_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link.device),
    .activeRegsA(activeRegsA), .activeRegsB(activeRegsB), .lsbFirst(devLsb));
  regbank_link_assertions checker_inst (.clk_sys(clk_sys), .rstn(rstn), .sclk(link.sclk), .csbN(link.csbN),
    .hostSdo(link.hostSdo), .hostSdoOeN(link.hostSdoOeN), .devSdo(link.devSdo), .devSdoOeN(link.devSdoOeN),
    .sdio(link.sdio));

  // Verdict and end of run
  task automatic finishTest();
    if (miscompares == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare one seen value against its expectation
  task automatic check(input string nm, input logic [`NREG*8-1:0] got, input logic [`NREG*8-1:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One frame through the host port; waits until the host is idle again
  task automatic xfer(input logic rd, input addr_t a, input byte_t d, output byte_t q);
    int n;
    q = 'x;
    n = 0;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= a;
    reqData <= d;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    // Bounded wait; the answer pulse lasts one cycle, so look every cycle
    do begin
      @(negedge clk_sys);
      if (rspValid === 1'b1) begin
        q = rspData;
      end
      n++;
    end while ((reqReady !== 1'b1 || n < 2) && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      $display("[ERR] frame end expected ready seen timeout");
    end
  endtask

  task automatic wr(input addr_t a, input byte_t d);
    byte_t q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input string nm, input addr_t a, input byte_t e);
    byte_t q;
    xfer(1'b1, a, 8'h00, q);
    check(nm, q, e);
  endtask

  // Byte of a live image, channel B when ch is set
  function automatic byte_t act(input logic ch, input int i);
    return ch ? activeRegsB[i*8 +: 8] : activeRegsA[i*8 +: 8];
  endfunction

  // Main sequence
  initial begin
    defVec = '0;
    defVec[`IDX_GLOBAL_CLK*8 +: 8] = 8'h01;
    defVec[`IDX_OUTPUT_MODE*8 +: 8] = 8'h05;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    // Defaults after power-up
    check("imageA", activeRegsA, defVec);
    check("imageB", activeRegsB, defVec);
    check("lsbFirst", devLsb, 1'b0);
    rd("portCfg", `ADDR_PORT_CFG, 8'h18);
    rd("chanIdx", `ADDR_CHAN_IDX, 8'h03);
    // Shadowed writes stay pending until commit
    wr(`ADDR_CHAN_IDX, 8'h01);
    wr(13'h008, 8'h2A);
    check("pendingA", activeRegsA, defVec);
    rd("shadowA", 13'h008, 8'h2A);
    wr(`ADDR_CHAN_IDX, 8'h02);
    rd("shadowB", 13'h008, 8'h00);
    wr(13'h03E, 8'h15);
    wr(`ADDR_COMMIT, 8'h01);
    check("commitA0", act(0, 0), 8'h2A);
    check("commitB29", act(1, 29), 8'h15);
    check("keptA29", act(0, 29), 8'h00);
    rd("commitBit", `ADDR_COMMIT, 8'h00);
    // Both selects: write reaches both copies, read returns channel A
    wr(`ADDR_CHAN_IDX, 8'h03);
    wr(13'h00A, 8'h77);
    wr(`ADDR_COMMIT, 8'h01);
    check("bothA", act(0, 2), 8'h77);
    check("bothB", act(1, 2), 8'h77);
    wr(`ADDR_CHAN_IDX, 8'h02);
    wr(13'h00A, 8'h11);
    wr(`ADDR_COMMIT, 8'h01);
    check("onlyB", act(1, 2), 8'h11);
    check("untouchedA", act(0, 2), 8'h77);
    wr(`ADDR_CHAN_IDX, 8'h03);
    rd("readBoth", 13'h00A, 8'h77);
    // The global location is one copy whatever the selection
    wr(`ADDR_CHAN_IDX, 8'h01);
    wr(13'h009, 8'h00);
    wr(`ADDR_CHAN_IDX, 8'h02);
    rd("globalViaB", 13'h009, 8'h00);
    wr(`ADDR_COMMIT, 8'h01);
    check("globalA", act(0, 1), 8'h00);
    check("globalB", act(1, 1), 8'h00);
    // Range edges commit together; open addresses read zero
    wr(`ADDR_CHAN_IDX, 8'h03);
    foreach (edgeAddr[k]) wr(edgeAddr[k], 8'h3C + 8'(k));
    check("edgeHeld", act(0, 24), 8'h00);
    wr(`ADDR_COMMIT, 8'h01);
    foreach (edgeAddr[k]) check("edgeA", act(0, edgeIdx[k]), 8'h3C + 8'(k));
    foreach (openAddr[k]) rd("openAddr", openAddr[k], 8'h00);
    // LSB-first mode; port values are their own mirror, data bytes are not
    wr(`ADDR_PORT_CFG, 8'h5A);
    check("lsbOn", devLsb, 1'b1);
    @(posedge clk_sys) hostLsb <= 1'b1;
    rd("portCfgLsb", `ADDR_PORT_CFG, 8'h5A);
    rd("lsbData", 13'h00A, 8'h77);
    wr(`ADDR_PORT_CFG, 8'h18);
    @(posedge clk_sys) hostLsb <= 1'b0;
    check("lsbOff", devLsb, 1'b0);
    // Soft reset reloads the defaults
    wr(`ADDR_PORT_CFG, 8'h3C);
    check("softA", activeRegsA, defVec);
    rd("softIdx", `ADDR_CHAN_IDX, 8'h03);
    // Hardware reset in mid-run
    wr(13'h008, 8'h33);
    wr(`ADDR_COMMIT, 8'h01);
    @(posedge clk_sys) rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    check("hardB", activeRegsB, defVec);
    rd("hardShadow", 13'h008, 8'h00);
    finishTest();
  end

  // Watchdog: about three and a half times the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    finishTest();
  end
endmodule
